// File: pex_pkg.sv
// shared constants and types for the port expander serial slave front end
// assumes a single core clock of 40 MHz; serial, strap and port pin inputs are asynchronous, load strobes come from core_clk logic
package pex_pkg;

  // core clock
  localparam int CLK_PERIOD_NS = 25;

  // spike suppression on the serial lines, longest pulse rejected
  localparam int SPIKE_NS = 50;
  localparam int SPIKE_CYC_RAW = SPIKE_NS / CLK_PERIOD_NS;
  localparam int SPIKE_CYC = (SPIKE_CYC_RAW < 1) ? 1 : SPIKE_CYC_RAW;
  localparam int SPIKE_W = 4;

  // fastest serial clock the slave is built for
  localparam int SCL_MAX_KHZ = 400;

  // slave addressing
  localparam logic [6:0] BASE_ADDR = 7'h42;
  localparam logic [4:0] TEN_BIT_HDR = 5'h1e;
  localparam logic [1:0] TEN_BIT_UPPER = 2'h0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // port pins
  localparam int PORT_W = 16;
  localparam logic [15:0] DIR_RESET = 16'h0000;
  localparam logic [15:0] OUT_RESET = 16'h0000;

  // slave sequencer, gray along idle-address-ack-selected
  typedef enum logic [2:0] {
    PEX_IDLE = 3'h0,
    PEX_ADDR = 3'h1,
    PEX_ACK = 3'h3,
    PEX_SEL = 3'h2,
    PEX_ADDR2 = 3'h6,
    PEX_IGNORE = 3'h4
  } pex_state_e;

endpackage

// File: pex_line_if.sv
// carrier for filtered serial line levels and bus events
// assumes producer and consumer share core_clk
interface pex_line_if;
  logic sclLevel;
  logic sdaLevel;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;

  modport prod (output sclLevel, sdaLevel, sclRise, sclFall, startSeen, stopSeen);
  modport cons (input sclLevel, sdaLevel, sclRise, sclFall, startSeen, stopSeen);
endinterface

// File: pex_line_filter.sv
// synchronises and de-glitches the serial clock and data pins, finds edges and bus conditions
// assumes scl and sda come from outside the core clock domain
module pex_line_filter (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clkEn,
  // raw pins
  input wire logic sclPin,
  input wire logic sdaPin,
  // filtered view
  pex_line_if.prod line
);

  logic [1:0] sclSync;
  logic [1:0] sdaSync;
  logic [pex_pkg::SPIKE_W-1:0] sclCnt;
  logic [pex_pkg::SPIKE_W-1:0] sdaCnt;
  logic sclF;
  logic sdaF;

  // two flip-flop synchronisers, first stage feeds only the second
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sclSync <= 2'h3;
      sdaSync <= 2'h3;
    end else if (clkEn) begin
      sclSync <= {sclSync[0], sclPin};
      sdaSync <= {sdaSync[0], sdaPin};
    end
  end

  // a level change is accepted only after it stays put past the spike window
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sclCnt <= '0;
      sdaCnt <= '0;
      sclF <= 1'b1;
      sdaF <= 1'b1;
    end else if (clkEn) begin
      if (sclSync[1] == sclF) begin
        sclCnt <= '0;
      end else if (sclCnt == pex_pkg::SPIKE_W'(pex_pkg::SPIKE_CYC)) begin
        sclF <= sclSync[1];
        sclCnt <= '0;
      end else begin
        sclCnt <= sclCnt + 1'b1;
      end
      if (sdaSync[1] == sdaF) begin
        sdaCnt <= '0;
      end else if (sdaCnt == pex_pkg::SPIKE_W'(pex_pkg::SPIKE_CYC)) begin
        sdaF <= sdaSync[1];
        sdaCnt <= '0;
      end else begin
        sdaCnt <= sdaCnt + 1'b1;
      end
    end
  end

  // registered levels, edges and start or stop while the clock is high
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      line.sclLevel <= 1'b1;
      line.sdaLevel <= 1'b1;
      line.sclRise <= 1'b0;
      line.sclFall <= 1'b0;
      line.startSeen <= 1'b0;
      line.stopSeen <= 1'b0;
    end else if (clkEn) begin
      line.sclLevel <= sclF;
      line.sdaLevel <= sdaF;
      line.sclRise <= sclF & ~line.sclLevel;
      line.sclFall <= ~sclF & line.sclLevel;
      line.startSeen <= sclF & line.sclLevel & line.sdaLevel & ~sdaF;
      line.stopSeen <= sclF & line.sclLevel & ~line.sdaLevel & sdaF;
    end
  end

endmodule // pex_line_filter

// File: pex_port_ctrl.sv
// port pin direction, output levels, per-pin wakeup and the interrupt pin driver
// assumes pin inputs are asynchronous and load strobes come from core_clk logic
module pex_port_ctrl (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clkEn,
  // configuration from the register side
  input wire logic dirLoad,
  input wire logic [15:0] dirValue,
  input wire logic outLoad,
  input wire logic [15:0] outValue,
  input wire logic [15:0] wakeEn,
  input wire logic intReq,
  // pins
  input wire logic [15:0] portIn,
  output logic [15:0] portOut,
  output logic [15:0] portOe,
  output logic [15:0] portSample,
  output logic wakeEvent,
  output logic intOut,
  output logic intOe
);

  logic [15:0] pinSync0;
  logic [15:0] pinSync1;
  logic [15:0] pinPrev;

  // direction: all pins inputs from reset, each pin set on its own
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      portOe <= pex_pkg::DIR_RESET;
    end else if (clkEn && dirLoad) begin
      portOe <= dirValue;
    end
  end

  // output levels
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      portOut <= pex_pkg::OUT_RESET;
    end else if (clkEn && outLoad) begin
      portOut <= outValue;
    end
  end

  // pin synchronisers and history for change detection
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pinSync0 <= '0;
      pinSync1 <= '0;
      pinPrev <= '0;
      portSample <= '0;
    end else if (clkEn) begin
      pinSync0 <= portIn;
      pinSync1 <= pinSync0;
      pinPrev <= pinSync1;
      portSample <= pinSync1;
    end
  end

  // wakeup pulse on a change of any enabled input pin
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wakeEvent <= 1'b0;
    end else if (clkEn) begin
      wakeEvent <= |((pinSync1 ^ pinPrev) & wakeEn & ~portOe);
    end
  end

  // interrupt pin: open drain, pulled low while a request stands
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      intOut <= 1'b0;
      intOe <= 1'b0;
    end else if (clkEn) begin
      intOut <= 1'b0;
      intOe <= intReq;
    end
  end

endmodule // pex_port_ctrl

// File: pex_serial_slave.sv
// What this block does
// - after reset all sixteen port pins are inputs
// - the host sets each pin direction independently
// - every port pin set as an input can raise a wakeup on activity
// - a dedicated interrupt pin is driven toward the host
// - serial clock from zero up to 400 kHz is served
// - clock and data inputs are noise filtered before use
// - both 7-bit and 10-bit addressing answer to the same value
// - three straps choose one of eight addresses, 42h to 49h
// - direction bit follows the address, one reads, zero writes
// - a matching address is acknowledged in the ninth bit
// - a mismatch is not acknowledged and the rest is ignored
// - acknowledge pulls data low in the ninth clock, high means none
// - start is data falling while clock high; nothing happens before it
// - stop is data rising while clock high; it returns to idle
// - data is sampled on clock rise; it changes only while clock low
//
// top of the serial slave front end: address phase, acknowledge and port control
// assumes open-drain resolution of sda and the interrupt pin outside this module
module pex_serial_slave (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clkEn,
  // serial bus pins
  input wire logic sclPin,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // address straps
  input wire logic addrStrapBit0,
  input wire logic addrStrapBit1,
  input wire logic addrStrapBit2,
  // transaction status toward the data phase
  output logic addrHit,
  output logic readReq,
  output logic slaveSelected,
  output logic tenBitMode,
  output logic [6:0] ownAddr,
  // port configuration from the data phase
  input wire logic dirLoad,
  input wire logic [15:0] dirValue,
  input wire logic outLoad,
  input wire logic [15:0] outValue,
  input wire logic [15:0] wakeEn,
  input wire logic intReq,
  // port pins
  input wire logic [15:0] portIn,
  output logic [15:0] portOut,
  output logic [15:0] portOe,
  output logic [15:0] portSample,
  output logic wakeEvent,
  // interrupt pin
  output logic intOut,
  output logic intOe
);

  pex_line_if line ();

  pex_pkg::pex_state_e state;
  logic [7:0] shiftReg;
  logic [3:0] bitCnt;
  logic [2:0] strapSync0;
  logic [2:0] strapSync1;
  logic tenBitHeld;
  logic ackToSecond;
  logic ackIsRead;
  logic byteDone;

  // byte end, match verdicts and the moment of selection
  logic byteEnd;
  logic firstHit;
  logic secondHit;
  logic ackEnd;

  // address from straps, top strap most significant, base added
  function automatic logic [6:0] strap_addr(input logic [2:0] straps);
    strap_addr = pex_pkg::BASE_ADDR + {4'h0, straps};
  endfunction

  // header byte of a 10-bit address carrying our upper bits
  function automatic logic ten_hdr_hit(input logic [7:0] rx);
    ten_hdr_hit = (rx[7:3] == pex_pkg::TEN_BIT_HDR) && (rx[2:1] == pex_pkg::TEN_BIT_UPPER);
  endfunction

  // first address byte that names us: 7-bit match, 10-bit write header, or read header after a held match
  function automatic logic first_byte_hit(input logic [7:0] rx, input logic [6:0] own, input logic held);
    logic sevenHit;
    logic tenWrite;
    logic tenRead;
    sevenHit = (rx[7:1] == own);
    tenWrite = ten_hdr_hit(rx) && !rx[0];
    tenRead = ten_hdr_hit(rx) && rx[0] && held;
    first_byte_hit = sevenHit || tenWrite || tenRead;
  endfunction

  // second byte of a 10-bit address: a zero then our seven address bits
  function automatic logic second_byte_hit(input logic [7:0] rx, input logic [6:0] own);
    second_byte_hit = (rx == {1'b0, own});
  endfunction

  // serial line conditioning; 400 kHz bit times are long against the filter
  pex_line_filter u_filter (
    .core_clk(core_clk),
    .nrst(nrst),
    .clkEn(clkEn),
    .sclPin(sclPin),
    .sdaPin(sdaIn),
    .line(line.prod)
  );

  // port pins, wakeup and interrupt driver
  pex_port_ctrl u_port (
    .core_clk(core_clk),
    .nrst(nrst),
    .clkEn(clkEn),
    .dirLoad(dirLoad),
    .dirValue(dirValue),
    .outLoad(outLoad),
    .outValue(outValue),
    .wakeEn(wakeEn),
    .intReq(intReq),
    .portIn(portIn),
    .portOut(portOut),
    .portOe(portOe),
    .portSample(portSample),
    .wakeEvent(wakeEvent),
    .intOut(intOut),
    .intOe(intOe)
  );

  // a byte is complete once eight bits are in; it ends on the next clock fall
  assign byteDone = (bitCnt == pex_pkg::BITS_PER_BYTE);
  assign byteEnd = line.sclFall && byteDone;

  // match verdicts on the byte just shifted; secondHit feeds the sequencer and the data driver, firstHit only the data driver
  assign firstHit = first_byte_hit(shiftReg, ownAddr, tenBitHeld);
  assign secondHit = second_byte_hit(shiftReg, ownAddr);

  // ninth clock fall of the final address byte: the slave is selected
  assign ackEnd = (state == pex_pkg::PEX_ACK) && line.sclFall && !ackToSecond;

  // strap synchronisers, straps are static but arrive from pins
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      strapSync0 <= 3'h0;
      strapSync1 <= 3'h0;
    end else if (clkEn) begin
      strapSync0 <= {addrStrapBit2, addrStrapBit1, addrStrapBit0};
      strapSync1 <= strapSync0;
    end
  end

  // own address published for the data phase
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ownAddr <= pex_pkg::BASE_ADDR;
    end else if (clkEn) begin
      ownAddr <= strap_addr(strapSync1);
    end
  end

  // shift register and bit counter, sampled on each rising clock edge of an address byte
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      shiftReg <= 8'h00;
      bitCnt <= 4'h0;
    end else if (clkEn) begin
      // a start or stop realigns the byte, even in mid-byte
      if (line.startSeen || line.stopSeen) begin
        bitCnt <= 4'h0;
      end else if (line.sclRise && (state == pex_pkg::PEX_ADDR || state == pex_pkg::PEX_ADDR2)) begin
        shiftReg <= {shiftReg[6:0], line.sdaLevel};
        bitCnt <= bitCnt + 4'h1;
      end else if (line.sclFall && byteDone) begin
        bitCnt <= 4'h0;
      end
    end
  end

  // address sequencer
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= pex_pkg::PEX_IDLE;
      ackToSecond <= 1'b0;
      ackIsRead <= 1'b0;
    end else if (clkEn) begin
      if (line.stopSeen) begin
        state <= pex_pkg::PEX_IDLE;
      end else if (line.startSeen) begin
        state <= pex_pkg::PEX_ADDR;
      end else begin
        // address bytes are judged on the clock fall that ends their eighth bit
        unique case (state)
          pex_pkg::PEX_IDLE: begin
            state <= pex_pkg::PEX_IDLE;
          end
          pex_pkg::PEX_ADDR: begin
            if (line.sclFall && byteDone) begin
              if (shiftReg[7:1] == ownAddr) begin
                state <= pex_pkg::PEX_ACK;
                ackToSecond <= 1'b0;
                ackIsRead <= shiftReg[0];
              end else if (ten_hdr_hit(shiftReg) && !shiftReg[0]) begin
                state <= pex_pkg::PEX_ACK;
                ackToSecond <= 1'b1;
                ackIsRead <= 1'b0;
              end else if (ten_hdr_hit(shiftReg) && shiftReg[0] && tenBitHeld) begin
                state <= pex_pkg::PEX_ACK;
                ackToSecond <= 1'b0;
                ackIsRead <= 1'b1;
              end else begin
                state <= pex_pkg::PEX_IGNORE;
              end
            end
          end
          pex_pkg::PEX_ADDR2: begin
            if (line.sclFall && byteDone) begin
              if (secondHit) begin
                state <= pex_pkg::PEX_ACK;
                ackToSecond <= 1'b0;
                ackIsRead <= 1'b0;
              end else begin
                state <= pex_pkg::PEX_IGNORE;
              end
            end
          end
          pex_pkg::PEX_ACK: begin
            if (line.sclFall) begin
              state <= ackToSecond ? pex_pkg::PEX_ADDR2 : pex_pkg::PEX_SEL;
            end
          end
          pex_pkg::PEX_SEL: begin
            state <= pex_pkg::PEX_SEL;
          end
          pex_pkg::PEX_IGNORE: begin
            state <= pex_pkg::PEX_IGNORE;
          end
          default: begin
            state <= pex_pkg::PEX_IDLE;
          end
        endcase
      end
    end
  end

  // 10-bit selection survives a repeated start, cleared by stop or any first address byte that is not a 10-bit header
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tenBitHeld <= 1'b0;
    end else if (clkEn) begin
      if (line.stopSeen) begin
        tenBitHeld <= 1'b0;
      end else if (state == pex_pkg::PEX_ADDR2 && line.sclFall && byteDone) begin
        tenBitHeld <= secondHit;
      end else if (state == pex_pkg::PEX_ADDR && line.sclFall && byteDone && !ten_hdr_hit(shiftReg)) begin
        tenBitHeld <= 1'b0;
      end
    end
  end

  // data line driver: pull low through the ninth clock, release on its falling edge
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sdaOut <= 1'b0;
      sdaOe <= 1'b0;
    end else if (clkEn) begin
      sdaOut <= 1'b0;
      if (line.startSeen || line.stopSeen) begin
        sdaOe <= 1'b0;
      end else if (state == pex_pkg::PEX_ACK) begin
        sdaOe <= ~line.sclFall;
      end else if (state == pex_pkg::PEX_ADDR && byteEnd) begin
        sdaOe <= firstHit;
      end else if (state == pex_pkg::PEX_ADDR2 && byteEnd) begin
        sdaOe <= secondHit;
      end else begin
        sdaOe <= 1'b0;
      end
    end
  end

  // status toward the data phase
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      addrHit <= 1'b0;
      readReq <= 1'b0;
      slaveSelected <= 1'b0;
      tenBitMode <= 1'b0;
    end else if (clkEn) begin
      addrHit <= ackEnd;
      if (line.startSeen || line.stopSeen) begin
        slaveSelected <= 1'b0;
      end else if (ackEnd) begin
        slaveSelected <= 1'b1;
        readReq <= ackIsRead;
        tenBitMode <= tenBitHeld;
      end
    end
  end

endmodule // pex_serial_slave

// File: pex_serial_slave_sva.sv
// checker for the serial slave front end: acknowledge timing, status and port side
// assumes it sees only the top ports; the bench drops clkEn only for a few cycles in the port test
module pex_serial_slave_sva (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clkEn,
  // serial pins
  input wire logic sclPin,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  // straps and status
  input wire logic addrStrapBit0,
  input wire logic addrStrapBit1,
  input wire logic addrStrapBit2,
  input wire logic addrHit,
  input wire logic slaveSelected,
  input wire logic [6:0] ownAddr,
  // port side
  input wire logic dirLoad,
  input wire logic [15:0] dirValue,
  input wire logic [15:0] portOe,
  input wire logic intReq,
  input wire logic intOe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sclQ;
  logic sdaQ;
  logic framed;
  logic [2:0] straps;

  // strap value, top strap most significant
  assign straps = {addrStrapBit2, addrStrapBit1, addrStrapBit0};

  // framing seen on the raw pins: a start sets it, a stop clears it
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sclQ <= 1'b1;
      sdaQ <= 1'b1;
      framed <= 1'b0;
    end else begin
      sclQ <= sclPin;
      sdaQ <= sdaIn;
      if (sclPin && sclQ && (sdaQ != sdaIn)) framed <= sdaQ;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // straps held still long enough to pass the synchroniser
  sequence strapsQuiet;
    $stable(straps)[*6];
  endsequence

  // data rose while the clock was high
  sequence stopOnPins;
    $fell(framed);
  endsequence

  reset_dir_a: assert property (!$past(nrst) |-> portOe == 16'h0000)
    else $error("pins not all inputs after reset");
  dir_load_a: assert property (dirLoad && clkEn |=> portOe == $past(dirValue))
    else $error("direction load not applied");
  int_pin_a: assert property (clkEn |=> intOe == $past(intReq))
    else $error("interrupt pin does not follow request");
  own_addr_a: assert property (strapsQuiet |-> ownAddr == 7'h42 + {4'h0, straps})
    else $error("own address does not follow straps");
  ack_edge_a: assert property (!$stable(sdaOe) |-> !sclPin)
    else $error("data drive changed while clock high");
  ack_low_a: assert property (sdaOe |-> !sdaOut)
    else $error("acknowledge does not pull low");
  ack_start_a: assert property ($rose(sdaOe) |-> framed)
    else $error("acknowledge without a start");
  hit_ack_a: assert property (addrHit |-> $past(sdaOe, 20))
    else $error("address hit without ninth bit acknowledge");
  sel_hit_a: assert property (addrHit |=> slaveSelected)
    else $error("hit did not select the slave");
  stop_idle_a: assert property (stopOnPins |-> ##[1:16] !slaveSelected)
    else $error("stop did not return to idle");
endmodule // pex_serial_slave_sva

bind pex_serial_slave pex_serial_slave_sva chk (
  .core_clk, .nrst, .clkEn, .sclPin, .sdaIn, .sdaOut, .sdaOe, .addrStrapBit0, .addrStrapBit1,
  .addrStrapBit2, .addrHit, .slaveSelected, .ownAddr, .dirLoad, .dirValue, .portOe, .intReq, .intOe
);

// File: pex_i2c_master.sv
// bus master model: start, stop, bytes most significant bit first, ninth-bit sampling
// assumes an open-drain data line resolved in the bench with a pull-up
module pex_i2c_master #(
  parameter int Q = 30 // quarter bit in core cycles, about 333 kHz
) (
  // clock
  input wire logic core_clk,
  // bus
  input wire logic sdaBus,
  output logic scl,
  output logic sdaLow
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle bus: clock high and still, data released
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end

  // whole core cycles, so each pin change lands just after a rising edge
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // start or repeated start: data falls while the clock is high
  task automatic start_cond();
    wt(1);
    sdaLow <= 1'b0;
    wt(Q);
    scl <= 1'b1;
    wt(2 * Q);
    sdaLow <= 1'b1;
    wt(2 * Q);
    scl <= 1'b0;
    wt(Q);
  endtask

  // stop: data rises while the clock is high, then the bus rests
  task automatic stop_cond();
    wt(1);
    sdaLow <= 1'b1;
    wt(Q);
    scl <= 1'b1;
    wt(2 * Q);
    sdaLow <= 1'b0;
    wt(2 * Q);
  endtask

  // clock falls with no condition, for framing faults
  task automatic scl_low();
    wt(1);
    scl <= 1'b0;
    wt(Q);
  endtask

  // data pulled low for two core cycles with the clock high, shorter than the filter accepts
  task automatic sda_spike();
    wt(1);
    sdaLow <= 1'b1;
    wt(2);
    sdaLow <= 1'b0;
    wt(Q);
  endtask

  // one bit: data set while clock low, line sampled in the high phase
  task automatic bit_cycle(input logic drvLow, output logic seen);
    wt(1);
    sdaLow <= drvLow;
    wt(Q);
    scl <= 1'b1;
    wt(Q);
    seen = sdaBus;
    wt(Q);
    scl <= 1'b0;
    wt(Q);
  endtask

  // eight bits then a released ninth bit; seen is the ninth bit level
  task automatic send_byte(input logic [7:0] b, output logic seen);
    logic dummy;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(!b[i], dummy);
    end
    bit_cycle(1'b0, seen);
  endtask
endmodule // pex_i2c_master

// File: tb_pex_serial_slave.sv
// testbench for the serial slave front end: address phase on the bus, then the port side
// assumes the master model and the checker bound to the top module
module tb_pex_serial_slave;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LIMIT = 60000;
  logic core_clk;
  logic nrst;
  logic clkEn;
  logic [2:0] straps;
  logic dirLoad, outLoad, intReq;
  logic [15:0] dirValue, outValue, wakeEn, portIn;
  logic sdaOut, sdaOe, addrHit, readReq, slaveSelected, tenBitMode;
  logic [6:0] ownAddr;
  logic [15:0] portOut, portOe, portSample;
  logic wakeEvent, intOut, intOe, sclLine, mstLow;
  wire sdaBus;
  int errCount = 0;
  int checkCount = 0;
  int cycles = 0;

  // open-drain data line with pull-up
  assign sdaBus = !(mstLow || (sdaOe && !sdaOut));

  pex_serial_slave DUT (
    .core_clk(core_clk), .nrst(nrst), .clkEn(clkEn), .sclPin(sclLine), .sdaIn(sdaBus),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .addrStrapBit0(straps[0]), .addrStrapBit1(straps[1]),
    .addrStrapBit2(straps[2]), .addrHit(addrHit), .readReq(readReq), .slaveSelected(slaveSelected),
    .tenBitMode(tenBitMode), .ownAddr(ownAddr), .dirLoad(dirLoad), .dirValue(dirValue),
    .outLoad(outLoad), .outValue(outValue), .wakeEn(wakeEn), .intReq(intReq), .portIn(portIn),
    .portOut(portOut), .portOe(portOe), .portSample(portSample), .wakeEvent(wakeEvent),
    .intOut(intOut), .intOe(intOe)
  );

  pex_i2c_master mst (.core_clk(core_clk), .sdaBus(sdaBus), .scl(sclLine), .sdaLow(mstLow));

  // core clock, 25 ns
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] expd);
    checkCount++;
    if (seen !== expd) begin
      errCount++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, expd);
    end
  endtask

  task automatic tallyAndFinish();
    $display("checks %0d mismatches %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errCount++;
      tallyAndFinish();
    end
  end

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic test_reset();
    check(portOe, 16'h0000);
    check({15'h0, sdaOe}, 16'h0000);
    check({9'h0, ownAddr}, 16'h0042);
    $display("test_reset done");
  endtask

  task automatic test_straps();
    logic [6:0] a;
    logic seen;
    for (int s = 0; s < 8; s++) begin
      @(posedge core_clk);
      straps <= s[2:0];
      settle(10);
      a = 7'h42 + 7'(s);
      check({9'h0, ownAddr}, {9'h0, a});
      mst.start_cond();
      mst.send_byte({a, s[0]}, seen);
      check({15'h0, seen}, 16'h0000);
      check({15'h0, readReq}, {15'h0, s[0]});
      check({15'h0, slaveSelected}, 16'h0001);
      mst.stop_cond();
      settle(20);
      check({15'h0, slaveSelected}, 16'h0000);
    end
    @(posedge core_clk);
    straps <= 3'h0;
    settle(10);
    $display("test_straps done");
  endtask

  task automatic test_mismatch();
    logic [6:0] bad [3] = '{7'h41, 7'h4a, 7'h43};
    logic seen;
    for (int i = 0; i < 3; i++) begin
      mst.start_cond();
      mst.send_byte({bad[i], 1'b0}, seen);
      check({15'h0, seen}, 16'h0001);
      mst.send_byte(8'h84, seen);
      check({15'h0, seen}, 16'h0001);
      check({15'h0, slaveSelected}, 16'h0000);
      mst.stop_cond();
    end
    mst.sda_spike();
    mst.scl_low();
    mst.send_byte(8'h84, seen);
    check({15'h0, seen}, 16'h0001);
    mst.stop_cond();
    $display("test_mismatch done");
  endtask

  task automatic test_tenbit();
    logic seen;
    mst.start_cond();
    mst.send_byte(8'hf0, seen);
    check({15'h0, seen}, 16'h0000);
    mst.send_byte(8'h42, seen);
    check({15'h0, seen}, 16'h0000);
    check({15'h0, tenBitMode}, 16'h0001);
    check({15'h0, readReq}, 16'h0000);
    mst.start_cond();
    mst.send_byte(8'hf1, seen);
    check({15'h0, seen}, 16'h0000);
    check({15'h0, readReq}, 16'h0001);
    mst.stop_cond();
    mst.start_cond();
    mst.send_byte(8'h84, seen);
    check({15'h0, tenBitMode}, 16'h0000);
    mst.stop_cond();
    $display("test_tenbit done");
  endtask

  task automatic watch_wake(input int n, output logic got);
    got = 1'b0;
    repeat (n) begin
      @(posedge core_clk);
      #1;
      if (wakeEvent === 1'b1) got = 1'b1;
    end
  endtask

  task automatic test_port();
    logic got;
    @(posedge core_clk);
    dirLoad <= 1'b1;
    dirValue <= 16'ha5c3;
    outLoad <= 1'b1;
    outValue <= 16'h3c5a;
    @(posedge core_clk);
    dirLoad <= 1'b0;
    outLoad <= 1'b0;
    #1;
    check(portOe, 16'ha5c3);
    check(portOut, 16'h3c5a);
    @(posedge core_clk);
    intReq <= 1'b1;
    #1;
    check({15'h0, intOe}, 16'h0000);
    @(posedge core_clk);
    intReq <= 1'b0;
    #1;
    check({15'h0, intOe}, 16'h0001);
    check({15'h0, intOut}, 16'h0000);
    @(posedge core_clk);
    dirLoad <= 1'b1;
    dirValue <= 16'h0000;
    wakeEn <= 16'h0001;
    portIn[1] <= 1'b1;
    @(posedge core_clk);
    dirLoad <= 1'b0;
    watch_wake(10, got);
    check({15'h0, got}, 16'h0000);
    @(posedge core_clk);
    portIn[0] <= 1'b1;
    watch_wake(10, got);
    check({15'h0, got}, 16'h0001);
    check(portSample, 16'h0003);
    @(posedge core_clk);
    clkEn <= 1'b0;
    dirLoad <= 1'b1;
    dirValue <= 16'hffff;
    settle(3);
    check(portOe, 16'h0000);
    @(posedge core_clk);
    clkEn <= 1'b1;
    dirLoad <= 1'b0;
    settle(2);
    check(portOe, 16'h0000);
    $display("test_port done");
  endtask

  // reset, then the scenarios in turn
  initial begin
    nrst = 1'b0;
    clkEn = 1'b1;
    straps = 3'h0;
    dirLoad = 1'b0;
    dirValue = 16'h0000;
    outLoad = 1'b0;
    outValue = 16'h0000;
    wakeEn = 16'h0000;
    intReq = 1'b0;
    portIn = 16'h0000;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    settle(12);
    test_reset();
    test_straps();
    test_mismatch();
    test_tenbit();
    test_port();
    tallyAndFinish();
  end
endmodule // tb_pex_serial_slave
